/* File: common/rmtc_pkg.sv */
package rmtc_pkg;
  // ------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int NUM_SRC = 8;
  localparam int SRC_W = 3;
  localparam int CNT_W = 8;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFS_SRC_ADDR = 4'h0;
  localparam logic [3:0] OFS_DST_ADDR = 4'h1;
  localparam logic [3:0] OFS_COUNT_A = 4'h2;
  localparam logic [3:0] OFS_BLOCK_COUNT = 4'h3;
  localparam logic [3:0] OFS_MODE = 4'h4;
  localparam logic [3:0] OFS_ENABLE = 4'h5;
  localparam logic [3:0] OFS_STATUS = 4'h6;
  // ------------------------------------------------------------
  // Mode register fields
  // ------------------------------------------------------------
  localparam int MODE_SIZE_BIT = 0;
  localparam int MODE_SRC_MODE_LSB = 1;
  localparam int MODE_DST_MODE_LSB = 3;
  localparam int MODE_RPT_DST_BIT = 5;
  localparam int MODE_ISEL_BIT = 6;
  localparam logic [1:0] AM_FIXED = 2'h0;
  localparam logic [1:0] AM_INC = 2'h1;
  localparam logic [1:0] AM_DEC = 2'h2;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [15:0] RST_COUNT_A = 16'h0000;
  localparam logic [15:0] RST_BLOCK_COUNT = 16'h0000;
  localparam logic [6:0] RST_MODE = 7'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
endpackage

/* File: dv/rmtc_bus_model.sv */
`timescale 1ns/100ps
module rmtc_bus_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic i_slow,
  input wire logic [7:0] i_raise,
  input wire logic [7:0] i_ack,
  output logic [7:0] o_req,
  output logic [15:0] o_rdata,
  output logic o_done
);
  logic [7:0] pend;
  logic [1:0] wait_cnt;
  // Dropped in the ack cycle, else the source would fire again
  assign o_req = pend & ~i_ack;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pend <= 8'h00;
      wait_cnt <= 2'h0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
    end else begin
      pend <= (pend | i_raise) & ~i_ack;
      o_done <= 1'b0;
      // Inverted every cycle except one that answers a read, so the last read word does not stay on the bus
      o_rdata <= ~o_rdata;
      if ((i_rd || i_wr) && !o_done) begin
        if (wait_cnt >= {i_slow, i_slow}) begin
          o_done <= 1'b1;
          wait_cnt <= 2'h0;
          if (i_rd) o_rdata <= 16'($urandom);
        end else wait_cnt <= wait_cnt + 2'h1;
      end
    end
  end
endmodule

/* File: dv/rmtc_repeat_ctrl_assertions.sv */
`timescale 1ns/100ps
module rmtc_repeat_ctrl_assertions #(
  parameter int NUM_SRC = rmtc_pkg::NUM_SRC,
  parameter logic [NUM_SRC-1:0] SRC_PRESENT = 8'hef
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic [NUM_SRC-1:0] I_ACT_REQ,
  input wire logic [NUM_SRC-1:0] O_ACT_ACK,
  input wire logic O_BUS_RD,
  input wire logic O_BUS_WR,
  input wire logic O_BUS_WORD,
  input wire logic [rmtc_pkg::ADDR_W-1:0] O_BUS_ADDR,
  input wire logic [15:0] O_BUS_WDATA,
  input wire logic I_BUS_DONE,
  input wire logic O_CPU_IRQ
);
  default clocking dcb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RSTN);
  irq_never_a: assert property (!O_CPU_IRQ)
    else $error("completion interrupt raised");
  rd_wr_excl_a: assert property (!(O_BUS_RD && O_BUS_WR))
    else $error("read and write together");
  rd_to_wr_a: assert property (O_BUS_RD && I_BUS_DONE |=> O_BUS_WR)
    else $error("write did not follow read");
  one_move_a: assert property (O_BUS_WR && I_BUS_DONE |=>
    !O_BUS_RD && !O_BUS_WR && O_ACT_ACK == '0 ##1 $onehot(O_ACT_ACK))
    else $error("ack not two cycles after write");
  start_cause_a: assert property ($rose(O_BUS_RD) |-> $past(I_ACT_REQ) != '0)
    else $error("transfer without request");
  ack_present_a: assert property ((O_ACT_ACK & ~SRC_PRESENT) == '0)
    else $error("absent source acked");
  ack_single_a: assert property ($onehot0(O_ACT_ACK))
    else $error("several acks at once");
  rd_hold_a: assert property (O_BUS_RD && !I_BUS_DONE |=>
    O_BUS_RD && $stable(O_BUS_ADDR))
    else $error("read released early");
  wr_hold_a: assert property (O_BUS_WR && !I_BUS_DONE |=>
    O_BUS_WR && $stable(O_BUS_WDATA) && $stable(O_BUS_ADDR))
    else $error("write released early");
  size_hold_a: assert property (O_BUS_RD && I_BUS_DONE |=> $stable(O_BUS_WORD))
    else $error("size changed in transfer");
  cover property ($rose(O_BUS_RD));
  cover property (O_BUS_WR && !I_BUS_DONE ##1 O_BUS_WR);
  cover property (O_ACT_ACK[7]);
endmodule
bind rmtc_repeat_ctrl rmtc_repeat_ctrl_assertions #(
  .NUM_SRC(NUM_SRC),
  .SRC_PRESENT(SRC_PRESENT)
) u_chk (.*);

/* File: dv/test_repeat_mode_transfer_ctrl.sv */
`timescale 1ns/100ps
module test_repeat_mode_transfer_ctrl;
  logic I_MCLK = 1'b0;
  logic I_RSTN = 1'b0;
  logic [3:0] I_REG_ADDR = 4'h0;
  logic [31:0] I_REG_WDATA = 32'h0;
  logic I_REG_WR = 1'b0;
  logic I_REG_RD = 1'b0;
  logic [31:0] O_REG_RDATA;
  logic [7:0] I_ACT_REQ, O_ACT_ACK;
  logic O_BUS_RD, O_BUS_WR, O_BUS_WORD, I_BUS_DONE, O_CPU_IRQ;
  logic [23:0] O_BUS_ADDR;
  logic [15:0] O_BUS_WDATA, I_BUS_RDATA;
  logic slow = 1'b0;
  logic [7:0] raise = 8'h00;
  int fail_count = 0;
  int comparisons = 0;
  int moves = 0;
  int sa, da, base, rld, wrk, ss, ds, rpt_dst, msk;
  int order[6] = '{0, 1, 2, 3, 5, 7};
  rmtc_repeat_ctrl u_rmtc_repeat_ctrl (.*);
  rmtc_bus_model u_rmtc_bus_model (.i_clk(I_MCLK), .i_rstn(I_RSTN), .i_rd(O_BUS_RD),
    .i_wr(O_BUS_WR), .i_slow(slow), .i_raise(raise), .i_ack(O_ACT_ACK),
    .o_req(I_ACT_REQ), .o_rdata(I_BUS_RDATA), .o_done(I_BUS_DONE));
  initial forever #20 I_MCLK = ~I_MCLK;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("compares=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    I_REG_ADDR <= a;
    I_REG_WDATA <= d;
    I_REG_WR <= 1'b1;
    @(posedge I_MCLK);
    I_REG_WR <= 1'b0;
    @(posedge I_MCLK);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [31:0] exp);
    I_REG_ADDR <= a;
    I_REG_RD <= 1'b1;
    @(posedge I_MCLK);
    I_REG_RD <= 1'b0;
    @(posedge I_MCLK);
    chk(O_REG_RDATA, exp);
  endtask
  // Mode write goes first: address writes also set the reload base
  task automatic cfg(input int w, sm, dm, rdst, n, input logic [23:0] s, d);
    ss = (sm == 1) ? w + 1 : (sm == 2) ? -(w + 1) : 0;
    ds = (dm == 1) ? w + 1 : (dm == 2) ? -(w + 1) : 0;
    msk = w ? 16'hffff : 16'h00ff;
    rpt_dst = rdst;
    rld = n;
    wrk = n;
    sa = s;
    da = d;
    base = rdst ? d : s;
    wr(rmtc_pkg::OFS_MODE, {26'h0, rdst[0], dm[1:0], sm[1:0], w[0]});
    wr(rmtc_pkg::OFS_SRC_ADDR, {8'h0, s});
    wr(rmtc_pkg::OFS_DST_ADDR, {8'h0, d});
    wr(rmtc_pkg::OFS_COUNT_A, {16'h0, n[7:0], n[7:0]});
    wr(rmtc_pkg::OFS_ENABLE, 32'haf);
  endtask
  task automatic xfer(input int idx);
    logic [15:0] d;
    bit got;
    d = 16'h0;
    got = 1'b0;
    for (int n = 0; n < 60 && !got; n++) begin
      @(posedge I_MCLK);
      if (O_BUS_RD && I_BUS_DONE) begin
        chk(O_BUS_ADDR, sa[23:0]);
        d = I_BUS_RDATA;
        chk(O_BUS_WORD, msk[8]);
      end
      if (O_BUS_WR && I_BUS_DONE) begin
        chk(O_BUS_ADDR, da[23:0]);
        chk(O_BUS_WDATA & msk[15:0], d & msk[15:0]);
      end
      got = |O_ACT_ACK;
    end
    chk(O_ACT_ACK, 32'h1 << idx);
    if (!got) final_report();
    moves++;
    sa += ss;
    da += ds;
    wrk--;
    if (wrk == 0) begin
      wrk = rld;
      if (rpt_dst) da = base;
      else sa = base;
    end
  endtask
  initial begin
    void'($urandom(46));
    repeat (3) @(posedge I_MCLK);
    I_RSTN <= 1'b1;
    for (int i = 0; i < 16; i++) rdchk(i[3:0], 32'h0);
    cfg(1, 1, 2, 0, 3, 24'h001000, 24'h002000);
    wr(rmtc_pkg::OFS_BLOCK_COUNT, 32'h1);
    // Reserved source 4 raised too; it must stay unserved
    raise <= 8'hbf;
    @(posedge I_MCLK);
    raise <= 8'h00;
    foreach (order[k]) xfer(order[k]);
    repeat (8) begin
      @(posedge I_MCLK);
      chk(O_BUS_RD | O_ACT_ACK[4] | O_CPU_IRQ, 0);
    end
    rdchk(rmtc_pkg::OFS_COUNT_A, {16'h0, rld[7:0], wrk[7:0]});
    rdchk(rmtc_pkg::OFS_BLOCK_COUNT, 32'h1);
    cfg(0, 0, 1, 1, 256, 24'($urandom), 24'($urandom));
    for (int t = 0; t < 258; t++) begin
      slow <= 1'($urandom);
      raise <= 8'h80;
      @(posedge I_MCLK);
      raise <= 8'h00;
      xfer(7);
      if (t == 100) rdchk(rmtc_pkg::OFS_COUNT_A, {16'h0, rld[7:0], wrk[7:0]});
    end
    rdchk(rmtc_pkg::OFS_COUNT_A, {16'h0, rld[7:0], wrk[7:0]});
    rdchk(rmtc_pkg::OFS_SRC_ADDR, {8'h0, sa[23:0]});
    rdchk(rmtc_pkg::OFS_DST_ADDR, {8'h0, da[23:0]});
    rdchk(rmtc_pkg::OFS_STATUS, {16'h0, moves[15:0]});
    final_report();
  end
endmodule

/* File: verilog/rmtc_addr_step.sv */
`timescale 1ns/100ps
module rmtc_addr_step #(
  parameter int W = 24
) (
  input wire logic [W-1:0] i_addr,
  input wire logic [1:0] i_mode,
  input wire logic i_word,
  output logic [W-1:0] o_addr
);
  logic [W-1:0] step;

  always_comb begin
    step = i_word ? W'(2) : W'(1);
    unique case (i_mode)
      rmtc_pkg::AM_INC: o_addr = i_addr + step;
      rmtc_pkg::AM_DEC: o_addr = i_addr - step;
      default: o_addr = i_addr;
    endcase
  end
endmodule

/* File: verilog/rmtc_prio_enc.sv */
`timescale 1ns/100ps
module rmtc_prio_enc #(
  parameter int N = 8,
  parameter int W = 3
) (
  input wire logic [N-1:0] i_req,
  output logic o_any,
  output logic [W-1:0] o_idx
);
  // Bit 0 is the lowest vector number, so it wins
  always_comb begin
    o_any = 1'b0;
    o_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_idx = W'(i);
      end
    end
  end
endmodule

/* File: verilog/rmtc_repeat_ctrl.sv */
`timescale 1ns/100ps
module rmtc_repeat_ctrl #(
  parameter int NUM_SRC = rmtc_pkg::NUM_SRC,
  parameter logic [NUM_SRC-1:0] SRC_PRESENT = 8'hef
) (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA,
  input wire logic [NUM_SRC-1:0] I_ACT_REQ,
  output logic [NUM_SRC-1:0] O_ACT_ACK,
  output logic O_BUS_RD,
  output logic O_BUS_WR,
  output logic O_BUS_WORD,
  output logic [rmtc_pkg::ADDR_W-1:0] O_BUS_ADDR,
  output logic [15:0] O_BUS_WDATA,
  input wire logic [15:0] I_BUS_RDATA,
  input wire logic I_BUS_DONE,
  output logic O_CPU_IRQ
);
  localparam int AW = rmtc_pkg::ADDR_W;
  localparam int SW = rmtc_pkg::SRC_W;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_UPDATE} rmtc_state_e;

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  rmtc_state_e state, next_state;
  logic [AW-1:0] src_addr, next_src_addr;
  logic [AW-1:0] dst_addr, next_dst_addr;
  logic [AW-1:0] rpt_base, next_rpt_base;
  logic [7:0] count_reload_value, next_count_reload_value;
  logic [7:0] count_working_value, next_count_working_value;
  logic [15:0] block_count_register, next_block_count_register;
  logic [6:0] mode, next_mode;
  logic [NUM_SRC-1:0] activation_enable_bit, next_activation_enable_bit;
  logic [15:0] data, next_data;
  logic [SW-1:0] cur_src, next_cur_src;
  logic [NUM_SRC-1:0] ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic [15:0] xfer_total, next_xfer_total;

  logic [NUM_SRC-1:0] gated_req;
  logic req_any;
  logic [SW-1:0] req_idx;
  logic word;
  logic rpt_dst;
  logic [AW-1:0] src_step, dst_step;

  assign word = mode[rmtc_pkg::MODE_SIZE_BIT];
  assign rpt_dst = mode[rmtc_pkg::MODE_RPT_DST_BIT];

  // ------------------------------------------------------------
  // Activation gating and priority
  // ------------------------------------------------------------
  // Mask and priority level of the interrupt controller do not enter here; the lowest bit of gated_req wins
  assign gated_req = I_ACT_REQ & activation_enable_bit & SRC_PRESENT;

  rmtc_prio_enc #(
    .N(NUM_SRC),
    .W(SW)
  ) u_prio (
    .i_req(gated_req),
    .o_any(req_any),
    .o_idx(req_idx)
  );

  // ------------------------------------------------------------
  // Address steppers
  // ------------------------------------------------------------
  rmtc_addr_step #(
    .W(AW)
  ) u_src_step (
    .i_addr(src_addr),
    .i_mode(mode[rmtc_pkg::MODE_SRC_MODE_LSB +: 2]),
    .i_word(word),
    .o_addr(src_step)
  );

  rmtc_addr_step #(
    .W(AW)
  ) u_dst_step (
    .i_addr(dst_addr),
    .i_mode(mode[rmtc_pkg::MODE_DST_MODE_LSB +: 2]),
    .i_word(word),
    .o_addr(dst_step)
  );

  // ------------------------------------------------------------
  // Registers and transfer sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_src_addr = src_addr;
    next_dst_addr = dst_addr;
    next_rpt_base = rpt_base;
    next_count_reload_value = count_reload_value;
    next_count_working_value = count_working_value;
    next_block_count_register = block_count_register;
    next_mode = mode;
    next_activation_enable_bit = activation_enable_bit;
    next_data = data;
    next_cur_src = cur_src;
    next_ack = '0;
    next_xfer_total = xfer_total;

    unique case (state)
      ST_IDLE: begin
        if (req_any) begin
          next_cur_src = req_idx;
          next_state = ST_READ;
        end
      end
      ST_READ: begin
        if (I_BUS_DONE) begin
          next_data = word ? I_BUS_RDATA : {8'h00, I_BUS_RDATA[7:0]};
          next_state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (I_BUS_DONE) begin
          next_state = ST_UPDATE;
        end
      end
      ST_UPDATE: begin
        next_ack[cur_src] = 1'b1;
        next_xfer_total = xfer_total + 16'h0001;
        next_src_addr = src_step;
        next_dst_addr = dst_step;
        // Count 1 ends the cycle; 8'h00 reload stands for 256
        if (count_working_value == 8'h01) begin
          next_count_working_value = count_reload_value;
          if (rpt_dst) begin
            next_dst_addr = rpt_base;
          end else begin
            next_src_addr = rpt_base;
          end
        end else begin
          next_count_working_value = count_working_value - 8'h01;
        end
        next_state = ST_IDLE;
      end
    endcase

    // Software writes land after the sequencer so the last word written wins
    if (I_REG_WR) begin
      unique case (I_REG_ADDR)
        rmtc_pkg::OFS_SRC_ADDR: begin
          next_src_addr = I_REG_WDATA[AW-1:0];
          if (!next_mode[rmtc_pkg::MODE_RPT_DST_BIT]) begin
            next_rpt_base = I_REG_WDATA[AW-1:0];
          end
        end
        rmtc_pkg::OFS_DST_ADDR: begin
          next_dst_addr = I_REG_WDATA[AW-1:0];
          if (next_mode[rmtc_pkg::MODE_RPT_DST_BIT]) begin
            next_rpt_base = I_REG_WDATA[AW-1:0];
          end
        end
        rmtc_pkg::OFS_COUNT_A: begin
          next_count_reload_value = I_REG_WDATA[15:8];
          next_count_working_value = I_REG_WDATA[7:0];
        end
        rmtc_pkg::OFS_BLOCK_COUNT: begin
          next_block_count_register = I_REG_WDATA[15:0];
        end
        rmtc_pkg::OFS_MODE: begin
          next_mode = I_REG_WDATA[6:0];
        end
        rmtc_pkg::OFS_ENABLE: begin
          next_activation_enable_bit = I_REG_WDATA[NUM_SRC-1:0];
        end
        default: begin
        end
      endcase
    end

  end

  // ------------------------------------------------------------
  // Register read-back
  // ------------------------------------------------------------
  // Zero outside the answer cycle, so a stale word is never mistaken for data
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (I_REG_RD) begin
      unique case (I_REG_ADDR)
        rmtc_pkg::OFS_SRC_ADDR: next_rdata = 32'(src_addr);
        rmtc_pkg::OFS_DST_ADDR: next_rdata = 32'(dst_addr);
        rmtc_pkg::OFS_COUNT_A: next_rdata = {16'h0000, count_reload_value, count_working_value};
        rmtc_pkg::OFS_BLOCK_COUNT: next_rdata = {16'h0000, block_count_register};
        rmtc_pkg::OFS_MODE: next_rdata = {25'h0000000, mode};
        rmtc_pkg::OFS_ENABLE: next_rdata = 32'(activation_enable_bit);
        rmtc_pkg::OFS_STATUS: next_rdata = {14'h0000, state, xfer_total};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ------------------------------------------------------------
  // Sequencer and register file storage
  // ------------------------------------------------------------
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state <= ST_IDLE;
      src_addr <= rmtc_pkg::RST_ADDR[AW-1:0];
      dst_addr <= rmtc_pkg::RST_ADDR[AW-1:0];
      rpt_base <= rmtc_pkg::RST_ADDR[AW-1:0];
      count_reload_value <= rmtc_pkg::RST_COUNT_A[15:8];
      count_working_value <= rmtc_pkg::RST_COUNT_A[7:0];
      block_count_register <= rmtc_pkg::RST_BLOCK_COUNT;
      mode <= rmtc_pkg::RST_MODE;
      activation_enable_bit <= rmtc_pkg::RST_ENABLE[NUM_SRC-1:0];
      data <= 16'h0000;
      cur_src <= '0;
      ack <= '0;
      xfer_total <= 16'h0000;
    end else begin
      state <= next_state;
      src_addr <= next_src_addr;
      dst_addr <= next_dst_addr;
      rpt_base <= next_rpt_base;
      count_reload_value <= next_count_reload_value;
      count_working_value <= next_count_working_value;
      block_count_register <= next_block_count_register;
      mode <= next_mode;
      activation_enable_bit <= next_activation_enable_bit;
      data <= next_data;
      cur_src <= next_cur_src;
      ack <= next_ack;
      xfer_total <= next_xfer_total;
    end
  end

  // ------------------------------------------------------------
  // Bus outputs
  // ------------------------------------------------------------
  assign O_BUS_RD = (state == ST_READ);
  assign O_BUS_WR = (state == ST_WRITE);
  assign O_BUS_WORD = word;
  assign O_BUS_ADDR = (state == ST_WRITE) ? dst_addr : src_addr;
  assign O_BUS_WDATA = data;
  assign O_ACT_ACK = ack;
  assign O_REG_RDATA = rdata;
  // Working count reloads at 1 instead of stopping at zero, so no end-of-count request exists
  assign O_CPU_IRQ = 1'b0;
endmodule
